// [src/srr_status.sv]
// Purpose: status byte, questionable and standard event register groups
// Assumes: host commands arrive as register writes, queries as reads
// Notes: event inputs are one-cycle pulses or levels sampled each cycle
//
// Notes on behaviour
// (R1) status byte read returns serial-poll value, master summary untouched
// (R2) rising enabled status bit sets bit 6 until serial poll and requests service
// (R3) enable masks are written and read back as binary-weighted values
// (R4) clear status zeroes event registers, keeps enable masks
// (R5) preset leaves the service-request enable mask alone
// (R6) questionable condition is read-only, live, never cleared by reading
// (R7) questionable event bits latch until read or clear status
// (R8) enabled questionable events summarise into the status byte
// (R9) standard event bits latch until clear status or read
// (R10) enabled standard events summarise into status byte bit 5
// (R11) clear status zeroes events, empties error queue, cancels pending opc
// (R12) preset zeroes questionable and standard-operation enable masks
// (R13) stored power-on clear flag decides if masks clear at power on
// (R14) opc sets event bit 0 only after earlier commands finish
// (R15) standard event bits 0,2,3,4,5,7 used; others read 0
// (R16) questionable bits 0,4,5,7,8,9 used; others read 0
// (R17) serial poll returns status byte then clears master summary
// (R18) group summaries are OR of event AND enable, every cycle
//
// The address map and strobed register access were chosen for this implementation.
`include "srr_cfg.svh"

module srr_status (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic CLK_EN,
	// power-on indication, one pulse after power up
	input wire logic POWER_ON,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// device events
	input wire logic [15:0] QUES_COND,
	input wire logic [7:0] ESR_SET,
	input wire logic [5:0] STB_OTHER,
	input wire logic CMDS_DONE,
	input wire logic ERRQ_NONEMPTY,
	// outputs
	output logic ERRQ_CLEAR,
	output logic SRQ,
	output logic OPER_ENA_OUT
);
	// ****************
	// state
	// ****************
	logic [15:0] qevt_q, qevt_d, qena_q, qena_d, qcond_q;
	logic [7:0] esr_q, esr_d, ese_q, ese_d, sre_q, sre_d;
	logic [15:0] opena_q, opena_d;
	logic psc_q, psc_d, mss_q, mss_d, srq_q, srq_d;
	logic errq_q, errq_d, oper_q, oper_d;
	logic [7:0] sum_q, sum_d;
	logic [31:0] rdata_q, rdata_d;
	srr_pkg::srr_opc_t opc_q, opc_d;
	logic wr_cmd, cls, preset, sel_wr_opc, rd_qevt, rd_esr, rd_spoll;
	logic q_sum, e_sum;
	logic [7:0] stb_now, srq_vec;

	assign wr_cmd = WR && ADDR == `SRR_CMD_OFS;
	assign cls = wr_cmd && WDATA[`SRR_CMD_CLS];
	assign preset = wr_cmd && WDATA[`SRR_CMD_PRESET];
	assign sel_wr_opc = wr_cmd && WDATA[`SRR_CMD_OPC];
	assign rd_qevt = RD && ADDR == `SRR_QEVT_OFS;
	assign rd_esr = RD && ADDR == `SRR_ESR_OFS;
	assign rd_spoll = RD && ADDR == `SRR_SPOLL_OFS;

	// ****************
	// summaries
	// ****************
	always_comb begin
		q_sum = |(qevt_q & qena_q); // R18 R8
		e_sum = |(esr_q & ese_q); // R18 R10
		stb_now = {1'b0, e_sum, STB_OTHER[5:4], q_sum, STB_OTHER[2:0]};
		stb_now[`SRR_STB_QUES] = q_sum; // R8
		stb_now[`SRR_STB_ESB] = e_sum; // R10
		stb_now[`SRR_STB_MSS] = 1'b0;
		srq_vec = stb_now & sre_q & ~sum_q; // R2
	end

	// ****************
	// next state
	// ****************
	always_comb begin
		qevt_d = qevt_q;
		esr_d = esr_q;
		qena_d = qena_q;
		ese_d = ese_q;
		sre_d = sre_q;
		opena_d = opena_q;
		psc_d = psc_q;
		mss_d = mss_q;
		opc_d = opc_q;
		errq_d = 1'b0;
		sum_d = stb_now & sre_q;
		rdata_d = 32'h0000_0000;
		// reads return pre-clear value
		if (RD) begin
			unique case (ADDR)
			`SRR_STB_OFS, `SRR_SPOLL_OFS:
				rdata_d = {24'h00_0000, stb_now[7], mss_q, stb_now[5:0]}; // R1
			`SRR_SRE_OFS: rdata_d = {24'h00_0000, sre_q}; // R3
			`SRR_QCOND_OFS: rdata_d = {16'h0000, qcond_q}; // R6
			`SRR_QEVT_OFS: rdata_d = {16'h0000, qevt_q};
			`SRR_QENA_OFS: rdata_d = {16'h0000, qena_q}; // R3
			`SRR_ESR_OFS: rdata_d = {24'h00_0000, esr_q};
			`SRR_ESE_OFS: rdata_d = {24'h00_0000, ese_q}; // R3
			`SRR_PSC_OFS: rdata_d = {31'h0000_0000, psc_q}; // R13
			`SRR_OPENA_OFS: rdata_d = {16'h0000, opena_q};
			default: rdata_d = 32'h0000_0000;
			endcase
		end
		if (rd_qevt || cls) qevt_d = 16'h0000; // R7 R4 R11
		if (rd_esr || cls) esr_d = 8'h00; // R9 R4 R11
		if (rd_spoll) mss_d = 1'b0; // R17
		// sets win over clears
		qevt_d = qevt_d | (QUES_COND & ~qcond_q & `SRR_QUES_USED); // R7 R16
		esr_d = esr_d | (ESR_SET & `SRR_ESR_USED); // R9 R15
		if (POWER_ON) begin
			esr_d[`SRR_ESR_PON] = 1'b1; // R15
			if (psc_q) ese_d = 8'h00; // R13
			if (psc_q) sre_d = 8'h00; // R13
		end
		if (|srq_vec) mss_d = 1'b1; // R2
		if (WR) begin
			unique case (ADDR)
			`SRR_SRE_OFS: sre_d = WDATA[7:0] & 8'hBF; // R3
			`SRR_QENA_OFS: qena_d = WDATA[15:0]; // R3
			`SRR_ESE_OFS: ese_d = WDATA[7:0]; // R3
			`SRR_PSC_OFS: psc_d = WDATA[0]; // R13
			`SRR_OPENA_OFS: opena_d = WDATA[15:0];
			default: ;
			endcase
		end
		if (preset) begin
			qena_d = 16'h0000; // R12 R5
			opena_d = 16'h0000; // R12
		end
		unique case (opc_q)
		srr_pkg::SRR_OPC_IDLE:
			if (sel_wr_opc && !cls) opc_d = srr_pkg::SRR_OPC_WAIT;
		srr_pkg::SRR_OPC_WAIT:
			if (cls) opc_d = srr_pkg::SRR_OPC_IDLE; // R11
			else if (CMDS_DONE) begin
				esr_d[`SRR_ESR_OPC] = 1'b1; // R14
				opc_d = srr_pkg::SRR_OPC_IDLE;
			end
		endcase
		if (cls && ERRQ_NONEMPTY) errq_d = 1'b1; // R11
		srq_d = |srq_vec; // R2
		oper_d = |opena_d;
	end

	// ****************
	// registers
	// ****************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			qevt_q <= 16'h0000;
			qena_q <= 16'h0000;
			qcond_q <= 16'h0000;
			esr_q <= 8'h00;
			ese_q <= 8'h00;
			sre_q <= 8'h00;
			opena_q <= 16'h0000;
			psc_q <= `SRR_PSC_RST;
			mss_q <= 1'b0;
			srq_q <= 1'b0;
			errq_q <= 1'b0;
			sum_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			opc_q <= srr_pkg::SRR_OPC_IDLE;
			oper_q <= 1'b0;
		end else if (CLK_EN) begin
			qevt_q <= qevt_d;
			qena_q <= qena_d;
			qcond_q <= QUES_COND & `SRR_QUES_USED; // R6 R16
			esr_q <= esr_d;
			ese_q <= ese_d;
			sre_q <= sre_d;
			opena_q <= opena_d;
			psc_q <= psc_d;
			mss_q <= mss_d;
			srq_q <= srq_d;
			errq_q <= errq_d;
			sum_q <= sum_d;
			rdata_q <= rdata_d;
			opc_q <= opc_d;
			oper_q <= oper_d;
		end
	end

	assign RDATA = rdata_q;
	assign SRQ = srq_q;
	assign ERRQ_CLEAR = errq_q;
	assign OPER_ENA_OUT = oper_q;

	// ****************
	// checks
	// ****************
	sequence s_cls;
		wr_cmd && WDATA[`SRR_CMD_CLS] && CLK_EN;
	endsequence
	property p_cls_evt;
		@(posedge REF_CLK) disable iff (RESET)
		s_cls ##0 (ESR_SET == 8'h00 && !POWER_ON) |=> esr_q == 8'h00;
	endproperty
	a_cls_evt: assert property (p_cls_evt) else $error("cls left esr"); // R11
	property p_cls_mask;
		@(posedge REF_CLK) disable iff (RESET)
		s_cls ##0 (!WR || ADDR == `SRR_CMD_OFS) && !POWER_ON
			&& !preset |=> $stable(ese_q) && $stable(qena_q);
	endproperty
	a_cls_mask: assert property (p_cls_mask) else $error("cls hit mask"); // R4
	property p_preset;
		@(posedge REF_CLK) disable iff (RESET)
		preset && CLK_EN |=> qena_q == 16'h0000 && opena_q == 16'h0000;
	endproperty
	a_preset: assert property (p_preset) else $error("preset failed"); // R12
	property p_preset_sre;
		@(posedge REF_CLK) disable iff (RESET)
		preset && CLK_EN && !POWER_ON |=> $stable(sre_q);
	endproperty
	a_preset_sre: assert property (p_preset_sre) else $error("sre lost"); // R5
	property p_esb;
		@(posedge REF_CLK) disable iff (RESET)
		RD && ADDR == `SRR_STB_OFS && CLK_EN
			|=> RDATA[`SRR_STB_ESB] == $past(|(esr_q & ese_q));
	endproperty
	a_esb: assert property (p_esb) else $error("esb summary"); // R10
	property p_srq;
		@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && |(stb_now & sre_q & ~sum_q) |=> SRQ && mss_q;
	endproperty
	a_srq: assert property (p_srq) else $error("no service request"); // R2
	property p_stb_keep;
		@(posedge REF_CLK) disable iff (RESET)
		RD && ADDR == `SRR_STB_OFS && CLK_EN && mss_q |=> mss_q;
	endproperty
	a_stb_keep: assert property (p_stb_keep) else $error("stb read cleared"); // R1
	property p_unused;
		@(posedge REF_CLK) disable iff (RESET)
		(esr_q & ~`SRR_ESR_USED) == 8'h00 && (qevt_q & ~`SRR_QUES_USED) == 16'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit set"); // R15
	property p_qlatch;
		@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !rd_qevt && !cls |=> (qevt_q & $past(qevt_q)) == $past(qevt_q);
	endproperty
	a_qlatch: assert property (p_qlatch) else $error("ques event lost"); // R7
	property p_opc;
		@(posedge REF_CLK) disable iff (RESET)
		opc_q == srr_pkg::SRR_OPC_WAIT && CMDS_DONE && CLK_EN && !cls
			|=> esr_q[`SRR_ESR_OPC];
	endproperty
	a_opc: assert property (p_opc) else $error("opc not set"); // R14
	sequence s_poll;
		rd_spoll && CLK_EN;
	endsequence
	property p_spoll_clr;
		@(posedge REF_CLK) disable iff (RESET)
		s_poll ##0 !(|srq_vec) |=> !mss_q;
	endproperty
	a_spoll_clr: assert property (p_spoll_clr) else $error("poll kept mss"); // R17
	property p_qcond_keep;
		@(posedge REF_CLK) disable iff (RESET)
		RD && ADDR == `SRR_QCOND_OFS && CLK_EN
			|=> qcond_q == ($past(QUES_COND) & `SRR_QUES_USED);
	endproperty
	a_qcond_keep: assert property (p_qcond_keep) else $error("qcond lost"); // R6
	property p_qc_unused;
		@(posedge REF_CLK) disable iff (RESET)
		(qcond_q & ~`SRR_QUES_USED) == 16'h0000;
	endproperty
	a_qc_unused: assert property (p_qc_unused) else $error("bad qcond"); // R16
	property p_esr_latch;
		@(posedge REF_CLK) disable iff (RESET)
		CLK_EN && !rd_esr && !cls
			|=> (esr_q & $past(esr_q)) == $past(esr_q);
	endproperty
	a_esr_latch: assert property (p_esr_latch) else $error("esr lost"); // R9
	property p_pon_clr;
		@(posedge REF_CLK) disable iff (RESET)
		POWER_ON && CLK_EN && psc_q && !WR
			|=> ese_q == 8'h00 && sre_q == 8'h00;
	endproperty
	a_pon_clr: assert property (p_pon_clr) else $error("pon kept mask"); // R13
	property p_pon_keep;
		@(posedge REF_CLK) disable iff (RESET)
		POWER_ON && CLK_EN && !psc_q && !WR
			|=> $stable(ese_q) && $stable(sre_q);
	endproperty
	a_pon_keep: assert property (p_pon_keep) else $error("pon lost mask"); // R13
	property p_ques_sum;
		@(posedge REF_CLK) disable iff (RESET)
		RD && ADDR == `SRR_STB_OFS && CLK_EN
			|=> RDATA[`SRR_STB_QUES] == $past(|(qevt_q & qena_q));
	endproperty
	a_ques_sum: assert property (p_ques_sum) else $error("ques summary"); // R8
	property p_opc_cancel;
		@(posedge REF_CLK) disable iff (RESET)
		s_cls |=> opc_q == srr_pkg::SRR_OPC_IDLE;
	endproperty
	a_opc_cancel: assert property (p_opc_cancel) else $error("opc kept"); // R11
	property p_errq;
		@(posedge REF_CLK) disable iff (RESET)
		s_cls ##0 ERRQ_NONEMPTY |=> ERRQ_CLEAR;
	endproperty
	a_errq: assert property (p_errq) else $error("error queue kept"); // R11
	// clock enable low freezes every register
	property p_freeze;
		@(posedge REF_CLK) disable iff (RESET)
		!CLK_EN |=> $stable(esr_q) && $stable(qevt_q)
			&& $stable(mss_q) && $stable(RDATA);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved");
endmodule : srr_status

// [src/srr_cfg.svh]
// Purpose: constants for the status reporting registers
// Assumes: 32-bit plain register port, word offsets as byte addresses
// Notes: definitions only
`ifndef SRR_CFG_SVH
`define SRR_CFG_SVH
// ****************
// register offsets
// ****************
`define SRR_STB_OFS 8'h00
`define SRR_SRE_OFS 8'h04
`define SRR_QCOND_OFS 8'h08
`define SRR_QEVT_OFS 8'h0C
`define SRR_QENA_OFS 8'h10
`define SRR_ESR_OFS 8'h14
`define SRR_ESE_OFS 8'h18
`define SRR_CMD_OFS 8'h1C
`define SRR_PSC_OFS 8'h20
`define SRR_OPENA_OFS 8'h24
`define SRR_SPOLL_OFS 8'h28
// ****************
// command bits in the command register
// ****************
`define SRR_CMD_CLS 0
`define SRR_CMD_PRESET 1
`define SRR_CMD_OPC 2
// ****************
// field positions
// ****************
`define SRR_STB_QUES 3
`define SRR_STB_ESB 5
`define SRR_STB_MSS 6
`define SRR_ESR_OPC 0
`define SRR_ESR_PON 7
// ****************
// used-bit masks and reset values
// ****************
`define SRR_ESR_USED 8'hBD
`define SRR_QUES_USED 16'h03B1
`define SRR_PSC_RST 1'h1
`endif

// [src/srr_pkg.sv]
// Purpose: types for the status reporting registers
// Assumes: nothing
// Notes: constants live in srr_cfg.svh
package srr_pkg;
	typedef enum logic [0:0] {
		SRR_OPC_IDLE = 1'b0,
		SRR_OPC_WAIT = 1'b1
	} srr_opc_t;
endpackage : srr_pkg

// [verif/srr_host_model.sv]
// Purpose: host side of the status register port
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes: idle address and data show the inverse of the last value
module srr_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask : rd_reg
endmodule : srr_host_model

// [verif/tb_srr_status.sv]
// Purpose: self-checking bench for the status reporting registers
// Assumes: host model drives the register port
// Notes: pulse outputs are counted every cycle
`include "srr_cfg.svh"
module tb_srr_status;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0, reset = 1'b1, power_on = 1'b0, cmds_done = 1'b0;
	logic clk_en = 1'b1;
	logic [5:0] stb_other = 6'h00;
	logic errq_nonempty = 1'b0, wr, rd, errq_clear, srq, oper_ena_out;
	logic [15:0] ques_cond = 16'h0000;
	logic [7:0] esr_set = 8'h00;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	int num_errors = 0, tests_run = 0, cycles = 0, srq_n = 0, clr_n = 0;
	srr_status srr_status_i (.REF_CLK(ref_clk), .RESET(reset), .CLK_EN(clk_en),
		.POWER_ON(power_on), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .QUES_COND(ques_cond), .ESR_SET(esr_set),
		.STB_OTHER(stb_other), .CMDS_DONE(cmds_done),
		.ERRQ_NONEMPTY(errq_nonempty), .ERRQ_CLEAR(errq_clear), .SRQ(srq),
		.OPER_ENA_OUT(oper_ena_out));
	srr_host_model host_i (.clk(ref_clk), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ****************
	// checks and closing
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		host_i.rd_reg(a, d);
		chk(d, exp);
	endtask : rc
	task automatic test_done;
		if (num_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	task automatic pon;
		@(posedge ref_clk);
		power_on <= 1'b1;
		@(posedge ref_clk);
		power_on <= 1'b0;
	endtask : pon
	always @(posedge ref_clk) begin
		cycles++;
		if (srq === 1'b1) srq_n++;
		if (errq_clear === 1'b1) clr_n++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	// ****************
	// tests
	// ****************
	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rc(`SRR_PSC_OFS, 32'h1);
		pon();
		rc(`SRR_ESR_OFS, 32'h80);
		rc(`SRR_ESR_OFS, 32'h0);
		@(posedge ref_clk) esr_set <= 8'hFF;
		@(posedge ref_clk) esr_set <= 8'h00;
		rc(`SRR_ESR_OFS, 32'hBD);
		@(posedge ref_clk) ques_cond <= 16'hFFFF;
		rc(`SRR_QCOND_OFS, 32'h3B1);
		rc(`SRR_QCOND_OFS, 32'h3B1);
		rc(`SRR_QEVT_OFS, 32'h3B1);
		rc(`SRR_QEVT_OFS, 32'h0);
		rc(8'h3C, 32'h0);
		@(posedge ref_clk) ques_cond <= 16'h0000;
		host_i.wr_reg(`SRR_QENA_OFS, 32'h1);
		host_i.wr_reg(`SRR_SRE_OFS, 32'h8);
		rc(`SRR_SRE_OFS, 32'h8);
		@(posedge ref_clk) ques_cond <= 16'h0001;
		repeat (2) @(posedge ref_clk);
		rc(`SRR_STB_OFS, 32'h48);
		rc(`SRR_STB_OFS, 32'h48);
		rc(`SRR_SPOLL_OFS, 32'h48);
		rc(`SRR_STB_OFS, 32'h08);
		chk(srq_n, 1);
		@(posedge ref_clk) errq_nonempty <= 1'b1;
		host_i.wr_reg(`SRR_CMD_OFS, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(clr_n, 1);
		rc(`SRR_QEVT_OFS, 32'h0);
		rc(`SRR_QENA_OFS, 32'h1);
		host_i.wr_reg(`SRR_OPENA_OFS, 32'hFF);
		chk(oper_ena_out, 1);
		host_i.wr_reg(`SRR_CMD_OFS, 32'h2);
		chk(oper_ena_out, 0);
		rc(`SRR_QENA_OFS, 32'h0);
		rc(`SRR_SRE_OFS, 32'h8);
		host_i.wr_reg(`SRR_ESE_OFS, 32'h1);
		host_i.wr_reg(`SRR_CMD_OFS, 32'h4);
		repeat (5) @(posedge ref_clk);
		rc(`SRR_ESR_OFS, 32'h0);
		@(posedge ref_clk) cmds_done <= 1'b1;
		rc(`SRR_STB_OFS, 32'h20);
		rc(`SRR_ESR_OFS, 32'h1);
		@(posedge ref_clk) cmds_done <= 1'b0;
		host_i.wr_reg(`SRR_CMD_OFS, 32'h4);
		host_i.wr_reg(`SRR_CMD_OFS, 32'h1);
		@(posedge ref_clk) cmds_done <= 1'b1;
		rc(`SRR_ESR_OFS, 32'h0);
		host_i.wr_reg(`SRR_PSC_OFS, 32'h0);
		host_i.wr_reg(`SRR_ESE_OFS, 32'h20);
		pon();
		rc(`SRR_ESE_OFS, 32'h20);
		host_i.wr_reg(`SRR_PSC_OFS, 32'h1);
		pon();
		rc(`SRR_ESE_OFS, 32'h0);
		rc(`SRR_SRE_OFS, 32'h0);
		@(posedge ref_clk) stb_other <= 6'h3F;
		rc(`SRR_STB_OFS, 32'h17);
		@(posedge ref_clk) clk_en <= 1'b0;
		host_i.wr_reg(`SRR_ESE_OFS, 32'h3D);
		@(posedge ref_clk) clk_en <= 1'b1;
		rc(`SRR_ESE_OFS, 32'h0);
		test_done();
	end
endmodule : tb_srr_status
